// *** include/cpsw_regs.svh ***
`ifndef CPSW_REGS_SVH
`define CPSW_REGS_SVH
// Serial clock divide ratio from the bus clock
`define CPSW_CLK_DIV      36
// Most switch clock frequency in kHz
`define CPSW_MAX_CLK_KHZ  2000
// Control word width
`define CPSW_WORD_BITS    11
// Bit count field width
`define CPSW_CNT_W        4
// Divider counter width
`define CPSW_DIV_W        6
`endif

// *** include/cpsw_pkg.sv ***
package cpsw_pkg;
  typedef enum logic [3:0] {
    CPSW_IDLE  = 4'h1,
    CPSW_SHIFT = 4'h2,
    CPSW_LATCH = 4'h4,
    CPSW_DONE  = 4'h8
  } cpsw_state_e;
endpackage

// *** design/cpsw_clk_gen.sv ***
`include "cpsw_regs.svh"
module cpsw_clk_gen #(
  parameter int DIV = `CPSW_CLK_DIV
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      sclk,
  output logic      rise,
  output logic      fall
);
  logic [`CPSW_DIV_W-1:0] cnt;
  logic [`CPSW_DIV_W-1:0] half;

  assign half = `CPSW_DIV_W'(DIV / 2);

  // Divide by DIV, 50 percent duty
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else if (cnt == `CPSW_DIV_W'(DIV - 1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + `CPSW_DIV_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk <= 1'b0;
    end else begin
      sclk <= (cnt >= half);
    end
  end

  assign rise = (cnt == half);
  assign fall = (cnt == '0);
endmodule

// *** design/cpsw_serial_port.sv ***
`include "cpsw_regs.svh"
// Notes on behaviour
// RL1 - Data valid at serial clock rising edge
// RL2 - Clock pin input; config bit drives it
// RL3 - Serial clock at most 2 MHz
// RL4 - Own serial clock is bus clock over 36
// RL5 - Control word shifted out bit by bit
// RL6 - Latch strobe marks word valid
// RL7 - Latch pulldown strap selects EEPROM pins
// RL8 - Global reset: outputs off, registers cleared
// RL9 - System uses global reset only at boot
// RL10 - Bus reset: outputs off, registers reset
// RL11 - Suspend keeps registers, outputs still off
// RL12 - Everything timed by bus clock rising edge
// RL13 - Whole word before latch, data stable
module cpsw_serial_port #(
  parameter int WORD_BITS = `CPSW_WORD_BITS,
  parameter int DIV       = `CPSW_CLK_DIV
) (
  // Clock and resets
  input  wire logic                 REF_CLK,
  input  wire logic                 RST,
  input  wire logic                 GLOBAL_RESET_IN,
  input  wire logic                 PCI_RESET_IN,
  input  wire logic                 SUSPEND_IN,

  // Configuration and request
  input  wire logic                 SWITCH_CLOCK_OUTPUT_SELECT,
  input  wire logic [WORD_BITS-1:0] WORD_IN,
  input  wire logic                 WORD_VALID,
  output logic                      WORD_READY,

  // Switch clock pin
  input  wire logic                 SCLK_I,
  output logic                      SCLK_O,
  output logic                      SCLK_OE,

  // Data and latch pins
  output logic                      SDATA_O,
  output logic                      SDATA_OE,
  input  wire logic                 LATCH_I,
  output logic                      LATCH_O,
  output logic                      LATCH_OE,

  // Multifunction pin roles
  output logic                      EEPROM_MODE
);
  logic                   reg_rst;
  logic                   outs_off;
  logic                   sys_rst;

  logic                   int_sclk;
  logic                   int_rise;
  logic                   int_fall;

  logic                   ext_d;
  logic                   ext_rise;
  logic                   ext_fall;

  logic                   sel_rise;
  logic                   sel_fall;

  logic                   strap_taken;
  logic                   strap;

  logic [WORD_BITS-1:0]   shreg;
  logic [`CPSW_CNT_W-1:0] bits_left;
  logic                   latch;

  logic                   take;
  logic                   count_rise;
  logic                   last_rise;
  logic                   shift_fall;
  logic                   latch_end;

  cpsw_pkg::cpsw_state_e  state;
  cpsw_pkg::cpsw_state_e  next_state;

  // Either system reset, whatever the suspend state
  assign sys_rst  = GLOBAL_RESET_IN | PCI_RESET_IN;
  // Suspend shields the registers from both resets
  assign reg_rst  = RST | (~SUSPEND_IN & sys_rst); // RL8 RL10 RL11
  // Pins float under any reset, suspended or not
  assign outs_off = RST | sys_rst; // RL8 RL10 RL11

  // 10 MHz / 36 is well under the switch limit
  cpsw_clk_gen #(.DIV(DIV)) u_clk_gen ( // RL3 RL4 RL12
    .clk  (REF_CLK),
    .rst  (reg_rst),
    .sclk (int_sclk),
    .rise (int_rise),
    .fall (int_fall)
  );

  // External clock taken as synchronous; edges from one delayed copy
  always_ff @(posedge REF_CLK) begin
    if (reg_rst) begin
      ext_d <= 1'b0;
    end else begin
      ext_d <= SCLK_I;
    end
  end
  assign ext_rise = SCLK_I & ~ext_d;
  assign ext_fall = ~SCLK_I & ext_d;

  // Edges of whichever clock the pin carries
  always_comb begin
    if (SWITCH_CLOCK_OUTPUT_SELECT) begin // RL2
      sel_rise = int_rise;
      sel_fall = int_fall;
    end else begin
      sel_rise = ext_rise;
      sel_fall = ext_fall;
    end
  end

  // Strap sensed on the first clock after reset, while the latch pin still floats
  always_ff @(posedge REF_CLK) begin
    if (reg_rst) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (reg_rst) begin
      strap <= 1'b0;
    end else if (!strap_taken) begin
      strap <= ~LATCH_I; // RL7
    end
  end

  // Frame events, decoded once for the state, counter and shifter
  assign take       = (state == cpsw_pkg::CPSW_IDLE) && WORD_VALID && strap_taken;
  assign count_rise = (state == cpsw_pkg::CPSW_SHIFT) && sel_rise && (bits_left != '0);
  assign last_rise  = (state == cpsw_pkg::CPSW_SHIFT) && sel_rise && (bits_left == '0);
  // No shift before the first rise, so the top bit is seen once
  assign shift_fall = (state == cpsw_pkg::CPSW_SHIFT) && sel_fall &&
                      (bits_left != `CPSW_CNT_W'(WORD_BITS - 1));
  assign latch_end  = (state == cpsw_pkg::CPSW_LATCH) && sel_fall;

  // A spare fall in the last state keeps the strobe apart from the next word
  always_comb begin
    next_state = state;
    unique case (state)
      cpsw_pkg::CPSW_IDLE: begin
        if (take) begin
          next_state = cpsw_pkg::CPSW_SHIFT;
        end
      end
      cpsw_pkg::CPSW_SHIFT: begin
        if (last_rise) begin
          next_state = cpsw_pkg::CPSW_LATCH;
        end
      end
      cpsw_pkg::CPSW_LATCH: begin
        if (latch_end) begin
          next_state = cpsw_pkg::CPSW_DONE;
        end
      end
      cpsw_pkg::CPSW_DONE: begin
        if (sel_fall) begin
          next_state = cpsw_pkg::CPSW_IDLE;
        end
      end
      default: begin
        next_state = cpsw_pkg::CPSW_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (reg_rst) begin
      state <= cpsw_pkg::CPSW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Rises still to come after the next one; zero marks the last bit
  always_ff @(posedge REF_CLK) begin
    if (reg_rst) begin
      bits_left <= '0;
    end else if (take) begin
      bits_left <= `CPSW_CNT_W'(WORD_BITS - 1);
    end else if (count_rise) begin
      bits_left <= bits_left - `CPSW_CNT_W'(1); // RL5
    end
  end

  // Once loaded, data changes only on falling edges, so it is settled at each rise
  always_ff @(posedge REF_CLK) begin
    if (reg_rst) begin
      shreg <= '0;
    end else if (take) begin
      shreg <= WORD_IN;
    end else if (shift_fall) begin
      shreg <= {shreg[WORD_BITS-2:0], 1'b0}; // RL1 RL5 RL13
    end
  end

  // Strobe rises one clock after the last rise, so the switch holds the bit already
  always_ff @(posedge REF_CLK) begin
    if (reg_rst) begin
      latch <= 1'b0;
    end else if (state == cpsw_pkg::CPSW_LATCH && !latch_end) begin
      latch <= 1'b1; // RL6 RL13
    end else begin
      latch <= 1'b0;
    end
  end

  assign WORD_READY  = (state == cpsw_pkg::CPSW_IDLE) && strap_taken;
  assign EEPROM_MODE = strap;
  // Pin enables drop under any reset
  assign SCLK_O      = int_sclk;
  assign SCLK_OE     = SWITCH_CLOCK_OUTPUT_SELECT & ~outs_off; // RL2
  assign SDATA_O     = shreg[WORD_BITS-1];
  assign SDATA_OE    = ~outs_off;
  // Latch pin floats until the strap has been sensed, else it reads itself
  assign LATCH_O     = latch;
  assign LATCH_OE    = ~outs_off & strap_taken; // RL7
endmodule

// *** verification/cpsw_checker.sv ***
module cpsw_checker #(parameter int DIV = 36) (
  input wire logic REF_CLK, RST, GLOBAL_RESET_IN, PCI_RESET_IN,
  input wire logic SWITCH_CLOCK_OUTPUT_SELECT, WORD_VALID, WORD_READY,
  input wire logic SCLK_O, SCLK_OE, SDATA_O, SDATA_OE, LATCH_O, LATCH_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic p, seen, rs;
  int run;
  assign rs = GLOBAL_RESET_IN | PCI_RESET_IN;
  // First edge after any reset is not timed, the divider phase is unknown there
  always_ff @(posedge REF_CLK) begin
    p <= SCLK_O;
    seen <= (RST | rs | !SWITCH_CLOCK_OUTPUT_SELECT) ? 1'b0 : seen | (SCLK_O != p);
    run <= (SCLK_O != p) ? 1 : run + 1;
  end
  sequence s_hold; $stable(SDATA_O) ##1 $stable(SDATA_O); endsequence
  sequence s_drop; ##[1:20] !LATCH_O; endsequence
  // Rises before a word is taken carry no bit, data may load there
  sequence s_counted_rise;
    $rose(SCLK_O) && SCLK_OE && !WORD_READY && !$past(WORD_READY);
  endsequence
  a_oe_reset: assert property (rs |-> !SCLK_OE && !SDATA_OE && !LATCH_OE)
    else $error("output enabled in reset");
  a_clk_input: assert property (!SWITCH_CLOCK_OUTPUT_SELECT |-> !SCLK_OE)
    else $error("clock pin driven");
  a_clk_drive: assert property (SWITCH_CLOCK_OUTPUT_SELECT && !rs |-> SCLK_OE)
    else $error("clock pin not driven");
  a_clk_rate: assert property (seen && SCLK_O != p |-> run == DIV / 2)
    else $error("clock half period wrong");
  a_data_hold: assert property (s_counted_rise |-> s_hold)
    else $error("data moved at clock rise");
  a_latch_end: assert property ($rose(LATCH_O) |-> s_drop)
    else $error("latch too long");
  a_latch_busy: assert property (LATCH_O |-> !WORD_READY)
    else $error("ready during latch");
  a_take_busy: assert property (WORD_VALID && WORD_READY |=> !WORD_READY)
    else $error("ready after take");
endmodule

// *** verification/cpsw_switch_model.sv ***
module cpsw_switch_model (
  input  wire logic        SCLK, SDATA, LATCH, EXT_EN,
  output logic             EXT_CLK, GOT,
  output logic [10:0]      WORD
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] sh;
  initial EXT_CLK = 0;
  initial GOT = 0;
  // 1 MHz, well under the switch ceiling
  always #500 EXT_CLK = EXT_EN & ~EXT_CLK;
  always @(posedge SCLK) sh <= {sh[9:0], SDATA};
  always @(posedge LATCH) begin
    WORD = sh;
    GOT = ~GOT;
  end
endmodule

// *** verification/cpsw_serial_port_bench.sv ***
module cpsw_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK = 0, RST = 1, GLOBAL_RESET_IN = 0, PCI_RESET_IN = 0, SUSPEND_IN = 0;
  logic SWITCH_CLOCK_OUTPUT_SELECT = 1, WORD_VALID = 0, strap = 0, ext_en = 0, mon = 0;
  logic WORD_READY, SCLK_O, SCLK_OE, SDATA_O, SDATA_OE, LATCH_O, LATCH_OE, EEPROM_MODE;
  logic ext, got, SCLK_I, LATCH_I;
  logic [10:0] WORD_IN = 11'h0, word, q[$];
  logic [31:0] rnd = 32'ha4e3a1ad;
  int err_total = 0, checked = 0;
  assign SCLK_I = SCLK_OE ? SCLK_O : ext;
  assign LATCH_I = LATCH_OE ? LATCH_O : strap;
  always #50 REF_CLK = ~REF_CLK;
  cpsw_serial_port DUT(.REF_CLK, .RST, .GLOBAL_RESET_IN, .PCI_RESET_IN, .SUSPEND_IN,
    .SWITCH_CLOCK_OUTPUT_SELECT, .WORD_IN, .WORD_VALID, .WORD_READY, .SCLK_I, .SCLK_O,
    .SCLK_OE, .SDATA_O, .SDATA_OE, .LATCH_I, .LATCH_O, .LATCH_OE, .EEPROM_MODE);
  // Released data line toggles so a stale bit cannot pass
  cpsw_switch_model SW(.SCLK(SCLK_I), .SDATA(SDATA_OE ? SDATA_O : REF_CLK),
    .LATCH(LATCH_I), .EXT_EN(ext_en), .EXT_CLK(ext), .WORD(word), .GOT(got));
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string n, input logic [10:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask
  always @(got) if (mon) chk("word", word, q.pop_front());
  initial begin
    step(5);
    RST = 0;
    step(2);
    chk("mode", 11'(EEPROM_MODE), 11'h1);
    mon = 1;
    for (int i = 0; i < 6; i++) begin
      if (i == 4) begin
        while (q.size() != 0) step(1);
        SWITCH_CLOCK_OUTPUT_SELECT = 0;
        ext_en = 1;
      end
      while (!WORD_READY) step(1);
      rnd = lfsr(rnd);
      WORD_IN = rnd[10:0];
      WORD_VALID = 1;
      q.push_back(rnd[10:0]);
      step(1);
      WORD_VALID = 0;
    end
    while (q.size() != 0) step(1);
    mon = 0;
    GLOBAL_RESET_IN = 1;
    step(3);
    chk("mode", 11'(EEPROM_MODE), 11'h0);
    GLOBAL_RESET_IN = 0;
    step(2);
    chk("mode", 11'(EEPROM_MODE), 11'h1);
    strap = 1;
    SUSPEND_IN = 1;
    GLOBAL_RESET_IN = 1;
    step(3);
    GLOBAL_RESET_IN = 0;
    step(2);
    chk("mode", 11'(EEPROM_MODE), 11'h1);
    SUSPEND_IN = 0;
    PCI_RESET_IN = 1;
    step(3);
    chk("mode", 11'(EEPROM_MODE), 11'h0);
    PCI_RESET_IN = 0;
    step(2);
    chk("mode", 11'(EEPROM_MODE), 11'h0);
    stop_test;
  end
  initial begin
    #3000000;
    err_total++;
    stop_test;
  end
endmodule
bind cpsw_serial_port cpsw_checker #(.DIV(DIV)) CHK(.REF_CLK, .RST, .GLOBAL_RESET_IN,
  .PCI_RESET_IN, .SWITCH_CLOCK_OUTPUT_SELECT, .WORD_VALID, .WORD_READY, .SCLK_O,
  .SCLK_OE, .SDATA_O, .SDATA_OE, .LATCH_O, .LATCH_OE);
